// ### rtl/reset_state_pkg.sv
// constants, register map and types for the reset state initializer
package reset_state_pkg;

   // apb geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = 10;
   localparam int REG_W = 8;
   localparam int PC_W = 13;

   // register indices (byte address is four times the index)
   localparam logic [IDX_W-1:0] IDX_INDIRECT = 10'h000;
   localparam logic [IDX_W-1:0] IDX_TIMER = 10'h001;
   localparam logic [IDX_W-1:0] IDX_PC_LOW = 10'h002;
   localparam logic [IDX_W-1:0] IDX_CPU_FLAGS = 10'h003;
   localparam logic [IDX_W-1:0] IDX_POINTER = 10'h004;
   localparam logic [IDX_W-1:0] IDX_PINS_A = 10'h005;
   localparam logic [IDX_W-1:0] IDX_PINS_B = 10'h006;
   localparam logic [IDX_W-1:0] IDX_PC_LATCH = 10'h00A;
   localparam logic [IDX_W-1:0] IDX_IRQ_CTRL = 10'h00B;
   localparam logic [IDX_W-1:0] IDX_PERIPH_FLAGS = 10'h00C;
   localparam logic [IDX_W-1:0] IDX_COMPARATOR = 10'h01F;
   localparam logic [IDX_W-1:0] IDX_OPTION = 10'h081;
   localparam logic [IDX_W-1:0] IDX_DIR_A = 10'h085;
   localparam logic [IDX_W-1:0] IDX_DIR_B = 10'h086;
   localparam logic [IDX_W-1:0] IDX_PERIPH_EN = 10'h08C;
   localparam logic [IDX_W-1:0] IDX_POWER_CAUSE = 10'h08E;
   localparam logic [IDX_W-1:0] IDX_VREF = 10'h09F;
   localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 10'h0C0;
   localparam logic [IDX_W-1:0] IDX_EVT_MASK = 10'h0C1;
   localparam logic [IDX_W-1:0] IDX_ACCUM = 10'h0C2;

   // cpu flags layout
   localparam logic [REG_W-1:0] FLAGS_TOP_MASK = 8'hE0;
   localparam logic [REG_W-1:0] FLAGS_LOW_MASK = 8'h07;
   localparam logic [REG_W-1:0] FLAGS_RO_MASK = 8'h18;
   localparam int TIMEOUT_BIT = 4;
   localparam int POWERDOWN_BIT = 3;
   localparam logic [REG_W-1:0] FLAGS_RESET_VAL = 8'h18;

   // power cause layout
   localparam int BROWNOUT_BIT = 0;
   localparam int POWERON_BIT = 1;
   localparam logic [REG_W-1:0] CAUSE_MASK = 8'h03;
   localparam logic [REG_W-1:0] CAUSE_RESET_VAL = 8'h00;

   // irq control layout
   localparam int GLOBAL_IRQ_EN_BIT = 7;
   localparam logic [REG_W-1:0] IRQ_CTRL_KEEP_MASK = 8'h01;
   localparam logic [REG_W-1:0] IRQ_CTRL_RESET_VAL = 8'h00;

   // program counter values
   localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
   localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
   localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

   localparam logic [REG_W-1:0] ALL_ONES = 8'hFF;
   localparam logic [REG_W-1:0] ALL_ZERO = 8'h00;

   // reset cause events, bit positions
   localparam int NUM_EVT = 7;
   localparam int EVT_POWERON = 0;
   localparam int EVT_BROWNOUT = 1;
   localparam int EVT_WDOG_RESET = 2;
   localparam int EVT_PIN_RUN = 3;
   localparam int EVT_PIN_SLEEP = 4;
   localparam int EVT_WDOG_WAKE = 5;
   localparam int EVT_IRQ_WAKE = 6;

   typedef enum logic [1:0] {
      INIT_KEEP = 2'h0,
      INIT_ZERO = 2'h1,
      INIT_ONES = 2'h2,
      INIT_PC = 2'h3
   } init_kind_t;

   typedef enum logic [1:0] {
      PC_IDLE = 2'h1,
      PC_WAIT_STEP = 2'h2
   } pc_state_t;

   // plain special registers held in cells
   localparam int NUM_CELLS = 14;
   localparam int CELL_PERIPH_FLAGS = 6;
   localparam logic [IDX_W-1:0] CELL_IDX [NUM_CELLS] = '{
      IDX_TIMER, IDX_PC_LOW, IDX_POINTER, IDX_PINS_A, IDX_PINS_B, IDX_PC_LATCH,
      IDX_PERIPH_FLAGS, IDX_COMPARATOR, IDX_OPTION, IDX_DIR_A, IDX_DIR_B,
      IDX_PERIPH_EN, IDX_VREF, IDX_ACCUM};
   localparam logic [REG_W-1:0] CELL_MASK [NUM_CELLS] = '{
      8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h40, 8'h3F, 8'hFF, 8'h1F,
      8'hFF, 8'h40, 8'hEF, 8'hFF};
   localparam init_kind_t CELL_INIT [NUM_CELLS] = '{
      INIT_KEEP, INIT_PC, INIT_KEEP, INIT_KEEP, INIT_KEEP, INIT_ZERO,
      INIT_ZERO, INIT_ZERO, INIT_ONES, INIT_ONES, INIT_ONES, INIT_ZERO,
      INIT_ZERO, INIT_KEEP};

endpackage : reset_state_pkg

// ### rtl/special_reg_cell.sv
// one special register with initial load, wake set and software write
`timescale 1ns/100ps
module special_reg_cell
   import reset_state_pkg::*;
#(
   parameter logic [REG_W-1:0] IMPL_MASK = 8'hFF,
   parameter logic [REG_W-1:0] RESET_VAL = 8'h00
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic initLoad,
   input wire logic [REG_W-1:0] initValue,
   input wire logic setEn,
   input wire logic [REG_W-1:0] setBits,
   input wire logic wrEn,
   input wire logic [REG_W-1:0] wrData,
   output logic [REG_W-1:0] value
);

   logic [REG_W-1:0] value_q;

   // initial load beats everything, wake-set bits are merged over a write
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         value_q <= RESET_VAL & IMPL_MASK;
      end else if (initLoad) begin
         value_q <= initValue & IMPL_MASK;
      end else if (wrEn || setEn) begin
         value_q <= ((wrEn ? wrData : value_q) | (setEn ? setBits : ALL_ZERO)) & IMPL_MASK;
      end
   end

   assign value = value_q;

endmodule : special_reg_cell

// ### rtl/reset_state_initializer.sv
// applies per-cause initial values to the special registers
//
// How it works
// - zero address on every non-wake reset
// - pin reset running: top clear, flags set
// - pin reset asleep: timeout set, powerdown clear
// - watchdog reset and wake flag patterns
// - irq wake: timeout set, powerdown clear, continue
// - irq wake with enable: step, then vector
// - brownout clears brownout flag, poweron dominates
// - poweron loads flags and clears poweron flag
// - wake keeps registers, sets waking irq flags
// - non-wake reset sets ones, clears listed registers
// - brownout bit0, poweron bit1, software sets
// - distinct flag pattern per cause, except brownout and pin reset running, which share one
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module reset_state_initializer
   import reset_state_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic powerOnEvent,
   input wire logic brownoutEvent,
   input wire logic watchdogResetEvent,
   input wire logic pinResetRunEvent,
   input wire logic pinResetSleepEvent,
   input wire logic watchdogWakeEvent,
   input wire logic irqWakeEvent,
   input wire logic [REG_W-1:0] wakeIrqCtrlFlags,
   input wire logic [REG_W-1:0] wakePeriphFlags,
   input wire logic [PC_W-1:0] pcCurrent,
   input wire logic instrDone,
   output logic [PC_W-1:0] pcValue,
   output logic pcLoad,
   output logic [REG_W-1:0] cpuFlags,
   output logic [REG_W-1:0] powerCause,
   output logic [REG_W-1:0] irqControl,
   output logic irq
);

   logic [NUM_EVT-1:0] evtRaw;
   logic [NUM_EVT-1:0] evtWin;
   logic nonWakeReset;
   logic anyWake;
   logic vectorTake;
   logic [IDX_W-1:0] regIdx;
   logic setupPhase;
   logic accessWrite;
   logic mapped;
   logic [REG_W-1:0] rdByte;
   logic [REG_W-1:0] wrByte;
   logic [REG_W-1:0] flags_q;
   logic [REG_W-1:0] flags_d;
   logic [REG_W-1:0] cause_q;
   logic [REG_W-1:0] cause_d;
   logic [REG_W-1:0] irqCtrl_q;
   logic [REG_W-1:0] irqCtrl_d;
   logic [NUM_EVT-1:0] evtStatus_q;
   logic [NUM_EVT-1:0] evtMask_q;
   logic [DATA_W-1:0] prdata_q;
   logic pslverr_q;
   logic [PC_W-1:0] pcValue_q;
   logic [PC_W-1:0] pcValue_d;
   logic pcLoad_q;
   logic pcLoad_d;
   pc_state_t pcState_q;
   pc_state_t pcState_d;
   logic [PC_W-1:0] pcNext;
   logic [REG_W-1:0] cellValue [NUM_CELLS];
   // cause resolution: poweron over brownout over the rest
   assign evtRaw[EVT_POWERON] = powerOnEvent;
   assign evtRaw[EVT_BROWNOUT] = brownoutEvent;
   assign evtRaw[EVT_WDOG_RESET] = watchdogResetEvent;
   assign evtRaw[EVT_PIN_RUN] = pinResetRunEvent;
   assign evtRaw[EVT_PIN_SLEEP] = pinResetSleepEvent;
   assign evtRaw[EVT_WDOG_WAKE] = watchdogWakeEvent;
   assign evtRaw[EVT_IRQ_WAKE] = irqWakeEvent;

   always_comb begin
      evtWin = '0;
      for (int i = 0; i < NUM_EVT; i++) begin
         if (evtRaw[i] && (evtWin == '0)) begin
            evtWin[i] = 1'b1;
         end
      end
   end

   assign nonWakeReset = evtWin[EVT_POWERON] | evtWin[EVT_BROWNOUT] | evtWin[EVT_WDOG_RESET]
      | evtWin[EVT_PIN_RUN] | evtWin[EVT_PIN_SLEEP];
   assign anyWake = evtWin[EVT_WDOG_WAKE] | evtWin[EVT_IRQ_WAKE];
   // apb decode
   assign regIdx = paddr[ADDR_W-1:2];
   assign setupPhase = psel && !penable;
   assign accessWrite = psel && penable && pwrite && mapped;
   assign wrByte = pwdata[REG_W-1:0];

   always_comb begin
      mapped = 1'b0;
      rdByte = ALL_ZERO;
      case (regIdx)
         IDX_INDIRECT: begin
            mapped = 1'b1;
         end
         IDX_CPU_FLAGS: begin
            mapped = 1'b1;
            rdByte = flags_q;
         end
         IDX_POWER_CAUSE: begin
            mapped = 1'b1;
            rdByte = cause_q;
         end
         IDX_IRQ_CTRL: begin
            mapped = 1'b1;
            rdByte = irqCtrl_q;
         end
         IDX_EVT_STATUS: begin
            mapped = 1'b1;
            rdByte = {1'b0, evtStatus_q};
         end
         IDX_EVT_MASK: begin
            mapped = 1'b1;
            rdByte = {1'b0, evtMask_q};
         end
         default: begin
            for (int i = 0; i < NUM_CELLS; i++) begin
               if (regIdx == CELL_IDX[i]) begin
                  mapped = 1'b1;
                  rdByte = cellValue[i];
               end
            end
         end
      endcase
   end

   // read data and error captured in the setup cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end else if (setupPhase) begin
         prdata_q <= (mapped && !pwrite) ? {{(DATA_W-REG_W){1'b0}}, rdByte} : '0;
         pslverr_q <= !mapped;
      end
   end

   assign pready = psel && penable;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q && psel && penable;

   // cpu flags: top bank bits, timeout, powerdown, low alu bits
   always_comb begin
      flags_d = flags_q;
      if (evtWin[EVT_POWERON]) begin
         flags_d = FLAGS_RESET_VAL;
      end else if (evtWin[EVT_BROWNOUT]) begin
         flags_d = (flags_q & FLAGS_LOW_MASK) | FLAGS_RO_MASK;
      end else if (evtWin[EVT_WDOG_RESET]) begin
         flags_d = flags_q & FLAGS_LOW_MASK;
         flags_d[POWERDOWN_BIT] = 1'b1;
      end else if (evtWin[EVT_PIN_RUN]) begin
         flags_d = (flags_q & FLAGS_LOW_MASK) | FLAGS_RO_MASK;
      end else if (evtWin[EVT_PIN_SLEEP]) begin
         flags_d = flags_q & FLAGS_LOW_MASK;
         flags_d[TIMEOUT_BIT] = 1'b1;
      end else if (evtWin[EVT_WDOG_WAKE]) begin
         flags_d = flags_q & ~FLAGS_RO_MASK;
      end else if (evtWin[EVT_IRQ_WAKE]) begin
         flags_d = flags_q & ~FLAGS_RO_MASK;
         flags_d[TIMEOUT_BIT] = 1'b1;
      end else if (accessWrite && (regIdx == IDX_CPU_FLAGS)) begin
         flags_d = (flags_q & FLAGS_RO_MASK) | (wrByte & ~FLAGS_RO_MASK);
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         flags_q <= FLAGS_RESET_VAL;
      end else begin
         flags_q <= flags_d;
      end
   end

   // power cause: brownout bit0, poweron bit1
   always_comb begin
      cause_d = cause_q;
      if (evtWin[EVT_POWERON]) begin
         cause_d[POWERON_BIT] = 1'b0;
      end else if (evtWin[EVT_BROWNOUT]) begin
         cause_d[BROWNOUT_BIT] = 1'b0;
      end else if (!nonWakeReset && !anyWake && accessWrite
         && (regIdx == IDX_POWER_CAUSE)) begin
         cause_d = wrByte & CAUSE_MASK;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cause_q <= CAUSE_RESET_VAL;
      end else begin
         cause_q <= cause_d;
      end
   end

   // irq control: keep lowest bit on reset, wake sets causing flags
   always_comb begin
      irqCtrl_d = irqCtrl_q;
      if (nonWakeReset) begin
         irqCtrl_d = irqCtrl_q & IRQ_CTRL_KEEP_MASK;
      end else begin
         if (accessWrite && (regIdx == IDX_IRQ_CTRL)) begin
            irqCtrl_d = wrByte;
         end
         if (vectorTake) begin
            irqCtrl_d[GLOBAL_IRQ_EN_BIT] = 1'b0;
         end
         if (anyWake) begin
            irqCtrl_d = irqCtrl_d | wakeIrqCtrlFlags;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irqCtrl_q <= IRQ_CTRL_RESET_VAL;
      end else begin
         irqCtrl_q <= irqCtrl_d;
      end
   end

   // program counter sequencing
   assign pcNext = pcCurrent + PC_STEP;

   always_comb begin
      pcState_d = pcState_q;
      pcValue_d = pcValue_q;
      pcLoad_d = 1'b0;
      vectorTake = 1'b0;
      if (nonWakeReset) begin
         pcValue_d = RESET_VECTOR;
         pcLoad_d = 1'b1;
         pcState_d = PC_IDLE;
      end else if (anyWake) begin
         pcValue_d = pcNext;
         pcLoad_d = 1'b1;
         if (evtWin[EVT_IRQ_WAKE] && irqCtrl_q[GLOBAL_IRQ_EN_BIT]) begin
            pcState_d = PC_WAIT_STEP;
         end else begin
            pcState_d = PC_IDLE;
         end
      end else begin
         case (pcState_q)
            PC_IDLE: begin
               pcState_d = PC_IDLE;
            end
            PC_WAIT_STEP: begin
               if (instrDone) begin
                  pcValue_d = IRQ_VECTOR;
                  pcLoad_d = 1'b1;
                  vectorTake = 1'b1;
                  pcState_d = PC_IDLE;
               end
            end
            default: begin
               pcState_d = PC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pcState_q <= PC_IDLE;
         pcValue_q <= RESET_VECTOR;
         pcLoad_q <= 1'b0;
      end else begin
         pcState_q <= pcState_d;
         pcValue_q <= pcValue_d;
         pcLoad_q <= pcLoad_d;
      end
   end

   // plain special registers
   for (genvar g = 0; g < NUM_CELLS; g++) begin : gCell
      logic initLoad;
      logic [REG_W-1:0] initValue;
      logic setEn;
      logic [REG_W-1:0] setBits;
      always_comb begin
         initLoad = 1'b0;
         initValue = ALL_ZERO;
         case (CELL_INIT[g])
            INIT_ZERO: begin
               initLoad = nonWakeReset;
            end
            INIT_ONES: begin
               initLoad = nonWakeReset;
               initValue = ALL_ONES;
            end
            INIT_PC: begin
               initLoad = pcLoad_d;
               initValue = pcValue_d[REG_W-1:0];
            end
            default: begin
               initLoad = 1'b0;
            end
         endcase
      end
      if (g == CELL_PERIPH_FLAGS) begin : gWake
         assign setEn = anyWake && !nonWakeReset;
         assign setBits = wakePeriphFlags;
      end else begin : gNoWake
         assign setEn = 1'b0;
         assign setBits = ALL_ZERO;
      end
      special_reg_cell #(
         .IMPL_MASK(CELL_MASK[g]),
         .RESET_VAL((CELL_INIT[g] == INIT_ONES) ? ALL_ONES : ALL_ZERO)
      ) uCell (
         .mclk(mclk),
         .reset_n(reset_n),
         .initLoad(initLoad),
         .initValue(initValue),
         .setEn(setEn),
         .setBits(setBits),
         .wrEn(accessWrite && (regIdx == CELL_IDX[g])),
         .wrData(wrByte),
         .value(cellValue[g])
      );
   end

   // cause event status, write one to clear, set wins
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         evtStatus_q <= '0;
      end else begin
         if (accessWrite && (regIdx == IDX_EVT_STATUS)) begin
            evtStatus_q <= (evtStatus_q & ~wrByte[NUM_EVT-1:0]) | evtWin;
         end else begin
            evtStatus_q <= evtStatus_q | evtWin;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         evtMask_q <= '0;
      end else if (accessWrite && (regIdx == IDX_EVT_MASK)) begin
         evtMask_q <= wrByte[NUM_EVT-1:0];
      end
   end

   assign irq = |(evtStatus_q & evtMask_q);
   assign pcValue = pcValue_q;
   assign pcLoad = pcLoad_q;
   assign cpuFlags = flags_q;
   assign powerCause = cause_q;
   assign irqControl = irqCtrl_q;

endmodule : reset_state_initializer

// ### dv/reset_state_props.sv
// assertions on the reset state initializer ports
`timescale 1ns/100ps
module reset_state_props
   import reset_state_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic powerOnEvent,
   input wire logic brownoutEvent,
   input wire logic watchdogResetEvent,
   input wire logic pinResetRunEvent,
   input wire logic pinResetSleepEvent,
   input wire logic watchdogWakeEvent,
   input wire logic irqWakeEvent,
   input wire logic [REG_W-1:0] wakeIrqCtrlFlags,
   input wire logic [REG_W-1:0] wakePeriphFlags,
   input wire logic [PC_W-1:0] pcCurrent,
   input wire logic instrDone,
   input wire logic [PC_W-1:0] pcValue,
   input wire logic pcLoad,
   input wire logic [REG_W-1:0] cpuFlags,
   input wire logic [REG_W-1:0] powerCause,
   input wire logic [REG_W-1:0] irqControl,
   input wire logic irq
);
   logic [6:0] ev;
   assign ev = {irqWakeEvent, watchdogWakeEvent, pinResetSleepEvent, pinResetRunEvent,
      watchdogResetEvent, brownoutEvent, powerOnEvent};
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   a_poweron_init: assert property (ev[0] |=> cpuFlags == 8'h18 && !powerCause[1]
      && powerCause[0] == $past(powerCause[0])) else $error("poweron init wrong");
   a_reset_vector: assert property ((|ev[4:0]) |=> pcLoad && pcValue == 13'h0000)
      else $error("reset vector wrong");
   a_brownout_cause: assert property (ev == 7'h02 |=> cpuFlags[7:3] == 5'h03
      && powerCause == {6'h00, $past(powerCause[1]), 1'h0}) else $error("brownout wrong");
   a_wdog_reset_flags: assert property (ev == 7'h04 |=> $stable(powerCause)
      && cpuFlags == {5'h01, $past(cpuFlags[2:0])}) else $error("watchdog reset wrong");
   a_pin_run_flags: assert property (ev == 7'h08 |=> $stable(powerCause)
      && cpuFlags == {5'h03, $past(cpuFlags[2:0])}) else $error("pin reset run wrong");
   a_pin_sleep_flags: assert property (ev == 7'h10 |=> $stable(powerCause)
      && cpuFlags == {5'h02, $past(cpuFlags[2:0])}) else $error("pin reset sleep wrong");
   a_wdog_wake_pc: assert property (ev == 7'h20 |=> cpuFlags == ($past(cpuFlags) & 8'hE7)
      && pcLoad && pcValue == $past(pcCurrent) + 13'h0001) else $error("watchdog wake wrong");
   a_irq_wake_flags: assert property (ev == 7'h40 |=> $stable(powerCause)
      && cpuFlags == (($past(cpuFlags) & 8'hE7) | 8'h10)) else $error("irq wake wrong");
   a_irq_vector_load: assert property (pcLoad && pcValue == 13'h0004 && $past(ev) == 7'h00
      |-> $past(instrDone) && !irqControl[7]) else $error("irq vector load wrong");
   a_nonwake_irqctrl: assert property ((|ev[4:0]) |=>
      irqControl == ($past(irqControl) & 8'h01)) else $error("irq control reset wrong");
   a_wake_sets_flags: assert property (ev[4:0] == 5'h00 && ev[6:5] != 2'h0 |=>
      irqControl == ($past(irqControl) | $past(wakeIrqCtrlFlags))) else $error("wake flags wrong");
endmodule : reset_state_props

bind reset_state_initializer reset_state_props props_u (.mclk, .reset_n, .paddr, .psel,
   .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .powerOnEvent, .brownoutEvent,
   .watchdogResetEvent, .pinResetRunEvent, .pinResetSleepEvent, .watchdogWakeEvent,
   .irqWakeEvent, .wakeIrqCtrlFlags, .wakePeriphFlags, .pcCurrent, .instrDone, .pcValue,
   .pcLoad, .cpuFlags, .powerCause, .irqControl, .irq);

// ### dv/core_model.sv
// processor core and cause detector model
`timescale 1ns/100ps
module core_model
   import reset_state_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic pcLoad,
   input wire logic [PC_W-1:0] pcValue,
   input wire logic [3:0] doneGap,
   output logic [PC_W-1:0] pcCurrent,
   output logic instrDone,
   output logic [NUM_EVT-1:0] causeEvents
);
   logic [4:0] doneCount_q;
   initial causeEvents = '0;
   // follows loaded pc, finishes one instruction doneGap+1 cycles after the pc is loaded
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pcCurrent <= 13'h0100;
         instrDone <= 1'h0;
         doneCount_q <= 5'h00;
      end else begin
         instrDone <= doneCount_q == 5'h01;
         if (pcLoad) begin
            pcCurrent <= pcValue;
            doneCount_q <= {1'h0, doneGap} + 5'h01;
         end else if (doneCount_q != 5'h00) begin
            doneCount_q <= doneCount_q - 5'h01;
         end
      end
   end
   // one-cycle cause pulse
   task fire(input int which);
      @(posedge mclk);
      causeEvents <= 7'h01 << which;
      @(posedge mclk);
      causeEvents <= '0;
   endtask : fire
endmodule : core_model

// ### dv/tb_reset_state_initializer.sv
// self-checking bench for the reset state initializer
`timescale 1ns/100ps
module tb_reset_state_initializer
   import reset_state_pkg::*;
;
   localparam logic [IDX_W-1:0] RST_IDX [6] = '{IDX_OPTION, IDX_DIR_A, IDX_DIR_B,
      IDX_CPU_FLAGS, IDX_POWER_CAUSE, IDX_IRQ_CTRL};
   localparam logic [7:0] RST_VAL [6] = '{8'hFF, 8'h1F, 8'hFF, 8'h18, 8'h00, 8'h00};
   localparam logic [IDX_W-1:0] SET_IDX [10] = '{IDX_TIMER, IDX_ACCUM, IDX_OPTION, IDX_DIR_B,
      IDX_PC_LATCH, IDX_COMPARATOR, IDX_VREF, IDX_IRQ_CTRL, IDX_PERIPH_FLAGS, IDX_INDIRECT};
   localparam logic [7:0] SET_VAL [10] = '{8'h5A, 8'h3C, 8'h00, 8'h00, 8'h15, 8'h2A, 8'h0F,
      8'h81, 8'h00, 8'h77};
   localparam logic [7:0] AFTER_VAL [10] = '{8'h5A, 8'h3C, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00,
      8'h03, 8'h40, 8'h00};
   localparam logic [7:0] FLAGS_EXP [7] = '{8'h18, 8'h1D, 8'h0D, 8'h1D, 8'h15, 8'hE5, 8'hF5};
   localparam logic [7:0] CAUSE_EXP [7] = '{8'h01, 8'h02, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03};
   logic mclk = 1'h0;
   logic reset_n = 1'h0;
   logic [ADDR_W-1:0] paddr = '0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [REG_W-1:0] wakeIrqCtrlFlags = 8'h02;
   logic [REG_W-1:0] wakePeriphFlags = 8'h40;
   logic [3:0] doneGap = 4'h0;
   logic [DATA_W-1:0] prdata;
   logic pready, pslverr, instrDone, pcLoad, irq;
   logic [PC_W-1:0] pcCurrent, pcValue;
   logic [REG_W-1:0] cpuFlags, powerCause, irqControl;
   logic [NUM_EVT-1:0] causeEvents;
   int errors = 0;
   int comparisons = 0;

   always #2 mclk = ~mclk;

   reset_state_initializer dut_u (.mclk, .reset_n, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .powerOnEvent(causeEvents[EVT_POWERON]),
      .brownoutEvent(causeEvents[EVT_BROWNOUT]), .watchdogResetEvent(causeEvents[EVT_WDOG_RESET]),
      .pinResetRunEvent(causeEvents[EVT_PIN_RUN]), .pinResetSleepEvent(causeEvents[EVT_PIN_SLEEP]),
      .watchdogWakeEvent(causeEvents[EVT_WDOG_WAKE]), .irqWakeEvent(causeEvents[EVT_IRQ_WAKE]),
      .wakeIrqCtrlFlags, .wakePeriphFlags, .pcCurrent, .instrDone, .pcValue, .pcLoad,
      .cpuFlags, .powerCause, .irqControl, .irq);
   core_model core_u (.mclk, .reset_n, .pcLoad, .pcValue, .doneGap, .pcCurrent, .instrDone,
      .causeEvents);

   task give_verdict();
      if (errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // apb transfer, held until pready is sampled high
   task apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd,
      output logic [7:0] rdat, output logic err);
      @(posedge mclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge mclk);
      penable <= 1'h1;
      @(posedge mclk);
      while (pready !== 1'h1) @(posedge mclk);
      rdat = prdata[7:0];
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic e;
      apb(1'h1, idx, d, r, e);
      #1;
   endtask : wr
   task rdc(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
      logic [7:0] r;
      logic e;
      apb(1'h0, idx, 8'h00, r, e);
      check(r, exp);
   endtask : rdc

   initial begin
      logic [7:0] r;
      logic e;
      logic [PC_W-1:0] pcExp;
      int k;
      repeat (10) @(posedge mclk);
      reset_n <= 1'h1;
      for (int j = 0; j < 6; j++) rdc(RST_IDX[j], RST_VAL[j]);
      apb(1'h0, 10'h3FF, 8'h00, r, e);
      check(e, 1'h1);
      check(r, 8'h00);
      for (int j = 0; j < 10; j++) wr(SET_IDX[j], SET_VAL[j]);
      for (int i = 0; i < NUM_EVT; i++) begin
         wr(IDX_CPU_FLAGS, 8'hE5);
         wr(IDX_POWER_CAUSE, 8'h03);
         pcExp = (i < EVT_WDOG_WAKE) ? RESET_VECTOR : pcCurrent + PC_STEP;
         core_u.fire(i);
         #1;
         check(pcLoad, 1'h1);
         check(pcValue, pcExp);
         rdc(IDX_CPU_FLAGS, FLAGS_EXP[i]);
         rdc(IDX_POWER_CAUSE, CAUSE_EXP[i]);
         rdc(IDX_EVT_STATUS, 8'h01 << i);
         check(irq, 1'h0);
         wr(IDX_EVT_MASK, 8'h7F);
         check(irq, 1'h1);
         wr(IDX_EVT_STATUS, 8'h01 << i);
         check(irq, 1'h0);
         rdc(IDX_EVT_STATUS, 8'h00);
         wr(IDX_EVT_MASK, 8'h00);
      end
      for (int j = 0; j < 10; j++) rdc(SET_IDX[j], AFTER_VAL[j]);
      wr(IDX_IRQ_CTRL, 8'h80);
      doneGap <= 4'h9;
      pcExp = pcCurrent + PC_STEP;
      core_u.fire(EVT_IRQ_WAKE);
      #1;
      check(pcValue, pcExp);
      k = 0;
      while (!(pcLoad === 1'h1 && pcValue === IRQ_VECTOR) && k < 40) begin
         @(posedge mclk);
         #1;
         k++;
      end
      check(pcValue, IRQ_VECTOR);
      rdc(IDX_IRQ_CTRL, 8'h02);
      wr(IDX_IRQ_CTRL, 8'h80);
      core_u.fire(EVT_IRQ_WAKE);
      core_u.fire(EVT_PIN_RUN);
      #1;
      check(pcValue, RESET_VECTOR);
      repeat (20) @(posedge mclk);
      #1;
      check(pcValue, RESET_VECTOR);
      rdc(IDX_IRQ_CTRL, 8'h00);
      give_verdict();
   end

   initial begin
      #100000;
      errors++;
      give_verdict();
   end
endmodule : tb_reset_state_initializer
